/* verilog/ocpb_pkg.sv */
// package for the overcurrent pickup and blocking stage
package ocpb_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] OCPB_GEN_OFS = 12'h000;
  localparam logic [11:0] OCPB_THR_OFS = 12'h004;
  localparam logic [11:0] OCPB_HARM_OFS = 12'h008;
  localparam logic [11:0] OCPB_DLY_OFS = 12'h00c;
  localparam logic [11:0] OCPB_STAT_OFS = 12'h010;
  localparam logic [11:0] OCPB_TIME_OFS = 12'h014;
  localparam logic [11:0] OCPB_RATIO_OFS = 12'h018;
  localparam logic [11:0] OCPB_THR_BUS_OFS = 12'h01c;
  // ---------------------------------------------------------------
  // reset values (currents in 0.01 x In, limits in 0.01 %, time in 5 ms ticks)
  // ---------------------------------------------------------------
  localparam logic [15:0] OCPB_THR_RST = 16'h0078;
  localparam logic [15:0] OCPB_HARM_LIM_RST = 16'h0001;
  localparam logic [15:0] OCPB_REL_DLY_RST = 16'h000c;
  localparam logic [15:0] OCPB_OP_DLY_RST = 16'h0014;
  localparam logic [15:0] OCPB_RESET_RATIO_PCT = 16'h0061;
  localparam logic [15:0] OCPB_PCT_FULL = 16'h0064;
  localparam logic [15:0] OCPB_HARM_SCALE = 16'h2710;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int OCPB_CLK_MHZ = 250;
  localparam int OCPB_TICK_US = 5000;
  localparam int OCPB_TICK_CYC = OCPB_TICK_US * OCPB_CLK_MHZ;
  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {OCPB_MAG_RMS, OCPB_MAG_TRMS, OCPB_MAG_PP, OCPB_MAG_RSV} ocpb_mag_e;
  typedef enum logic [2:0] {OCPB_LN_ON, OCPB_LN_BLOCKED, OCPB_LN_TEST, OCPB_LN_TEST_BLK, OCPB_LN_OFF} ocpb_ln_e;
  typedef enum logic [1:0] {OCPB_COND_NORMAL, OCPB_COND_START, OCPB_COND_TRIP, OCPB_COND_BLOCKED} ocpb_cond_e;
  // force: 0 normal, 1 start, 2 trip, 3 blocked, 4..9 start and a..f trip phase mask 1..6
  typedef logic [3:0] ocpb_force_t;
  typedef enum logic [1:0] {OCPB_ST_IDLE, OCPB_ST_RUN, OCPB_ST_RELEASE, OCPB_ST_BLOCKED} ocpb_st_e;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] rms;
    logic [15:0] trms;
    logic [15:0] pp;
    logic [15:0] h2;
  } ocpb_phase_s;
  typedef struct packed {
    ocpb_phase_s [2:0] ph;
  } ocpb_side_s;
  typedef struct packed {
    logic start;
    logic trip;
    logic blocked;
    logic [2:0] ph_start;
    logic [2:0] ph_trip;
  } ocpb_out_s;
endpackage : ocpb_pkg

/* verilog/ocpb_stage.sv */
// overcurrent pickup, blocking and status stage with apb settings
//
// Design decisions made here: the placing of the registers and the APB register port.
module ocpb_stage #(
  parameter int TICK_CYC = ocpb_pkg::OCPB_TICK_CYC // cycles per 5 ms program cycle
) (
  input wire logic clk_sys_in, // 250 mhz clock
  input wire logic srst_in, // sync reset, active high
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pwrite_in, // apb direction
  input wire logic [11:0] paddr_in, // apb byte address
  input wire logic [31:0] pwdata_in, // apb write data
  output logic [31:0] prdata_out, // apb read data
  output logic pready_out, // apb ready
  output logic pslverr_out, // apb error
  input wire ocpb_pkg::ocpb_side_s side1_in, // side 1 measurements
  input wire ocpb_pkg::ocpb_side_s side2_in, // side 2 measurements
  input wire logic ext_block_in, // blocking matrix input
  input wire logic force_enable_in, // global stage forcing enable
  input wire logic [15:0] group_thr_in, // threshold from active setting group
  input wire logic group_thr_load_in, // pulse: setting group change
  input wire logic [15:0] comm_thr_in, // threshold from comm bus
  input wire logic comm_thr_load_in, // pulse: comm bus threshold write
  output ocpb_pkg::ocpb_out_s status_out, // start/trip/blocked flags
  output ocpb_pkg::ocpb_cond_e cond_out, // overall condition
  output logic [2:0] mode_out // effective node mode
);
  import ocpb_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] tick_cnt;
    logic tick;
    logic [15:0] thr;
    logic [15:0] harm_lim;
    logic [15:0] rel_dly;
    logic [15:0] op_dly;
    ocpb_mag_e mag_sel;
    logic side2;
    logic comm_allow;
    ocpb_ln_e logical_node_mode;
    ocpb_force_t force_sel;
    logic inrush_en;
    logic delayed_rel;
    logic [2:0] pick;
    ocpb_st_e st;
    logic [15:0] op_cnt;
    logic [15:0] rel_cnt;
    logic [15:0] ratio;
    logic [15:0] imax;
    ocpb_out_s flags;
    ocpb_cond_e cond;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ocpb_state_s;

  ocpb_state_s q, d;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // magnitude by selection
  function automatic logic [15:0] pick_mag(input ocpb_phase_s p, input ocpb_mag_e s);
    case (s)
      OCPB_MAG_TRMS: pick_mag = p.trms;
      OCPB_MAG_PP: pick_mag = p.pp;
      default: pick_mag = p.rms;
    endcase
  endfunction : pick_mag

  // ratio a*100/b, saturating, b of zero gives all ones
  function automatic logic [15:0] pct_of(input logic [15:0] a, input logic [15:0] b);
    logic [31:0] r;
    r = 32'h0;
    if (b == 16'h0) begin
      r = 32'hffff;
    end else begin
      r = ({16'h0, a} * 32'(OCPB_PCT_FULL)) / {16'h0, b};
    end
    pct_of = (r > 32'hffff) ? 16'hffff : r[15:0];
  endfunction : pct_of

  // overall condition, trip outranks start, start outranks blocked
  function automatic ocpb_cond_e cond_of(input ocpb_out_s f);
    if (f.trip) begin
      cond_of = OCPB_COND_TRIP;
    end else if (f.start) begin
      cond_of = OCPB_COND_START;
    end else if (f.blocked) begin
      cond_of = OCPB_COND_BLOCKED;
    end else begin
      cond_of = OCPB_COND_NORMAL;
    end
  endfunction : cond_of

  // masks 7 are codes 1 and 2, so sixteen codes cover every listed combination
  function automatic ocpb_out_s force_flags(input ocpb_force_t f);
    force_flags = '0;
    case (f)
      4'h1: force_flags.ph_start = 3'h7;
      4'h2: force_flags.ph_trip = 3'h7;
      4'h3: force_flags.blocked = 1'b1;
      4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9: begin
        force_flags.ph_start = 3'(f - 4'h3);
      end
      default: begin
        if (f != 4'h0) begin
          force_flags.ph_trip = 3'(f - 4'h9);
        end
      end
    endcase
  endfunction : force_flags

  ocpb_side_s meas;
  logic [15:0] mag [3];
  logic [31:0] rel_lvl;
  logic inrush;
  logic apb_acc;
  logic blk_eff;
  logic any_pick;

  always_comb begin
    d = q;
    // ---------------------------------------------------------------
    // measurement selection and inrush detection
    // ---------------------------------------------------------------
    meas = q.side2 ? side2_in : side1_in;
    rel_lvl = {16'h0, q.thr} * 32'(OCPB_RESET_RATIO_PCT);
    inrush = 1'b0;
    for (int i = 0; i < 3; i++) begin
      mag[i] = pick_mag(meas.ph[i], q.mag_sel);
      // h2*10000 > lim*fund
      if (({16'h0, meas.ph[i].h2} * 32'(OCPB_HARM_SCALE)) > ({16'h0, q.harm_lim} * {16'h0, meas.ph[i].rms})) begin
        inrush = q.inrush_en;
      end
    end

    // ---------------------------------------------------------------
    // program cycle tick
    // ---------------------------------------------------------------
    d.tick = 1'b0;
    if (q.tick_cnt >= 32'(TICK_CYC - 1)) begin
      d.tick_cnt = 32'h0;
      d.tick = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 32'h1;
    end

    // ---------------------------------------------------------------
    // apb slave, answers in the access cycle with no wait
    // ---------------------------------------------------------------
    apb_acc = psel_in && penable_in;
    d.pready = psel_in && !penable_in;
    d.pslverr = 1'b0;
    d.prdata = 32'h0;
    if (psel_in && !penable_in) begin
      case (paddr_in)
        OCPB_GEN_OFS: d.prdata = {18'h0, q.force_sel, q.delayed_rel, q.inrush_en, q.logical_node_mode, q.comm_allow,
                                  q.side2, q.mag_sel, 1'b0};
        OCPB_THR_OFS: d.prdata = {16'h0, q.thr};
        OCPB_HARM_OFS: d.prdata = {16'h0, q.harm_lim};
        OCPB_DLY_OFS: d.prdata = {q.op_dly, q.rel_dly};
        OCPB_STAT_OFS: d.prdata = {18'h0, q.logical_node_mode, q.cond, q.flags};
        OCPB_TIME_OFS: d.prdata = {q.op_dly, 16'(q.op_dly - q.op_cnt)};
        OCPB_RATIO_OFS: d.prdata = {q.imax, q.ratio};
        OCPB_THR_BUS_OFS: d.prdata = 32'h0;
        default: d.pslverr = 1'b1;
      endcase
    end
    d.pslverr = d.pslverr && psel_in && !penable_in;
    if (apb_acc && q.pready && pwrite_in && !q.pslverr) begin
      case (paddr_in)
        OCPB_GEN_OFS: begin
          // general settings live here only, a group change never touches them
          d.mag_sel = ocpb_mag_e'(pwdata_in[2:1]);
          d.side2 = pwdata_in[3];
          d.comm_allow = pwdata_in[4];
          d.logical_node_mode = (pwdata_in[7:5] > 3'h4) ? OCPB_LN_OFF : ocpb_ln_e'(pwdata_in[7:5]);
          d.inrush_en = pwdata_in[8];
          d.delayed_rel = pwdata_in[9];
          d.force_sel = pwdata_in[13:10];
        end
        OCPB_THR_OFS: d.thr = pwdata_in[15:0];
        OCPB_HARM_OFS: d.harm_lim = pwdata_in[15:0];
        OCPB_DLY_OFS: begin
          d.rel_dly = pwdata_in[15:0];
          d.op_dly = pwdata_in[31:16];
        end
        OCPB_THR_BUS_OFS: begin
          if (q.comm_allow) begin
            d.thr = pwdata_in[15:0];
          end
        end
        default: d.thr = q.thr;
      endcase
    end
    if (group_thr_load_in) begin
      d.thr = group_thr_in;
    end
    if (comm_thr_load_in && q.comm_allow) begin
      d.thr = comm_thr_in;
    end

    // ---------------------------------------------------------------
    // protection processing, once per tick
    // ---------------------------------------------------------------
    blk_eff = 1'b0;
    any_pick = 1'b0;
    if (q.tick) begin
      blk_eff = ext_block_in || inrush || (q.logical_node_mode == OCPB_LN_BLOCKED) || (q.logical_node_mode == OCPB_LN_TEST_BLK);
      d.imax = 16'h0;
      for (int i = 0; i < 3; i++) begin
        // shared threshold, hysteresis at 97 percent
        if ({16'h0, mag[i]} * 32'(OCPB_PCT_FULL) > {16'h0, q.thr} * 32'(OCPB_PCT_FULL)) begin
          d.pick[i] = 1'b1;
        end else if ({16'h0, mag[i]} * 32'(OCPB_PCT_FULL) < rel_lvl) begin
          d.pick[i] = 1'b0;
        end
        if (mag[i] > d.imax) begin
          d.imax = mag[i];
        end
      end
      d.ratio = pct_of(d.imax, q.thr);
      any_pick = |d.pick;
      // ---------------------------------------------------------------
      // state machine
      // ---------------------------------------------------------------
      case (q.st)
        OCPB_ST_IDLE: begin
          if (any_pick && blk_eff) begin
            d.st = OCPB_ST_BLOCKED;
          end else if (any_pick) begin
            d.st = OCPB_ST_RUN;
            d.op_cnt = 16'h1;
          end
        end
        OCPB_ST_RUN: begin
          if (!any_pick || blk_eff) begin
            d.st = q.delayed_rel ? OCPB_ST_RELEASE : OCPB_ST_IDLE;
            d.rel_cnt = 16'h0;
            if (!q.delayed_rel) begin
              d.op_cnt = 16'h0;
            end
          end else if (q.op_cnt < q.op_dly) begin
            d.op_cnt = q.op_cnt + 16'h1;
          end
        end
        OCPB_ST_RELEASE: begin
          if (any_pick && !blk_eff) begin
            d.st = OCPB_ST_RUN;
          end else if (q.rel_cnt + 16'h1 >= q.rel_dly) begin
            d.st = OCPB_ST_IDLE;
            d.op_cnt = 16'h0;
          end else begin
            d.rel_cnt = q.rel_cnt + 16'h1;
          end
        end
        OCPB_ST_BLOCKED: begin
          if (!any_pick || !blk_eff) begin
            d.st = OCPB_ST_IDLE;
          end
        end
        default: d.st = OCPB_ST_IDLE;
      endcase
      if (q.logical_node_mode == OCPB_LN_OFF) begin
        d.st = OCPB_ST_IDLE;
        d.op_cnt = 16'h0;
      end

      // ---------------------------------------------------------------
      // status flags and forcing
      // ---------------------------------------------------------------
      d.flags = '0;
      if (d.st == OCPB_ST_RUN || d.st == OCPB_ST_RELEASE) begin
        d.flags.ph_start = (d.st == OCPB_ST_RUN) ? d.pick : q.flags.ph_start;
        if (d.st == OCPB_ST_RUN && d.op_cnt >= q.op_dly) begin
          d.flags.ph_trip = d.pick;
        end
      end
      d.flags.blocked = (d.st == OCPB_ST_BLOCKED);
      if (q.force_sel != 4'h0 && force_enable_in) begin
        d.flags = force_flags(q.force_sel);
      end
      d.flags.start = |d.flags.ph_start;
      d.flags.trip = |d.flags.ph_trip;
      d.cond = cond_of(d.flags);
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      q <= '0;
      q.thr <= OCPB_THR_RST;
      q.harm_lim <= OCPB_HARM_LIM_RST;
      q.rel_dly <= OCPB_REL_DLY_RST;
      q.op_dly <= OCPB_OP_DLY_RST;
      q.mag_sel <= OCPB_MAG_RMS;
      q.logical_node_mode <= OCPB_LN_ON;
      q.st <= OCPB_ST_IDLE;
      q.cond <= OCPB_COND_NORMAL;
      q.delayed_rel <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata_out = q.prdata;
  assign pready_out = q.pready;
  assign pslverr_out = q.pslverr;
  assign status_out = q.flags;
  assign cond_out = q.cond;
  assign mode_out = q.logical_node_mode;
endmodule : ocpb_stage

/* bench/ocpb_meas_model.sv */
// partner model: phase measurement chain refreshed each program tick
module ocpb_meas_model #(
  parameter int TK = 20 // cycles per program tick
) (
  input wire logic clk_in, // system clock
  input wire logic [2:0][15:0] lvl_in, // commanded phase level
  input wire logic [15:0] h2_in, // second harmonic level
  output ocpb_pkg::ocpb_side_s s1_out, // side 1 values
  output ocpb_pkg::ocpb_side_s s2_out // side 2 values
);
  import ocpb_pkg::*;
  int cnt = 0;
  // side 2 doubles rms so a side swap shows at the ports
  always @(posedge clk_in) begin
    cnt <= (cnt == TK - 1) ? 0 : cnt + 1;
    if (cnt == 0) begin
      for (int i = 0; i < 3; i++) begin
        // no harmonic without a fundamental, so idle phases never look like inrush
        s1_out.ph[i] <= {lvl_in[i], lvl_in[i] + 16'h20, lvl_in[i] << 1, (lvl_in[i] != 16'h0) ? h2_in : 16'h0};
        s2_out.ph[i] <= {lvl_in[i] << 1, lvl_in[i], lvl_in[i], 16'h0};
      end
    end
  end
endmodule : ocpb_meas_model

/* bench/ocpb_stage_monitor.sv */
// port checker for the overcurrent stage
module ocpb_stage_monitor (
  input wire logic clk_sys_in, // clock
  input wire logic srst_in, // reset
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pready_out, // apb ready
  input wire logic pslverr_out, // apb error
  input wire logic force_enable_in, // forcing enable
  input wire ocpb_pkg::ocpb_out_s status_out, // flags
  input wire ocpb_pkg::ocpb_cond_e cond_out, // condition
  input wire logic [2:0] mode_out // node mode
);
  import ocpb_pkg::*;
  // ---
  // properties
  // ---
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  chk_ready_after_setup: assert property (pready_out |-> $past(psel_in && !penable_in))
    else $error("ready without setup");
  chk_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("ready too long");
  chk_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  chk_start_from_phase: assert property (status_out.start == (|status_out.ph_start))
    else $error("phase start lost");
  chk_trip_from_phase: assert property (status_out.trip == (|status_out.ph_trip))
    else $error("phase trip lost");
  chk_trip_cond: assert property (status_out.trip |-> cond_out == OCPB_COND_TRIP)
    else $error("trip not in condition");
  chk_blocked_cond: assert property (status_out.blocked && !status_out.start && !status_out.trip
    |-> cond_out == OCPB_COND_BLOCKED) else $error("blocked not in condition");
  chk_mode_legal: assert property (mode_out <= 3'h4)
    else $error("mode out of range");
  chk_status_per_tick: assert property (!force_enable_in && $changed(status_out) |=> $stable(status_out)[*8])
    else $error("status moved between ticks");
  chk_trip_after_start: assert property (!force_enable_in && $rose(status_out.trip) |-> $past(status_out.start))
    else $error("trip without start");
endmodule : ocpb_stage_monitor

bind ocpb_stage ocpb_stage_monitor u_mon (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pready_out(pready_out), .pslverr_out(pslverr_out), .force_enable_in(force_enable_in),
  .status_out(status_out), .cond_out(cond_out), .mode_out(mode_out));

/* bench/ocpb_stage_tb.sv */
// self-checking bench for the overcurrent pickup and blocking stage
module ocpb_stage_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ocpb_pkg::*;
  localparam int TK = 20;
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic blk = 1'b0, fen = 1'b0, gld = 1'b0, cld = 1'b0, pready, pslverr, rerr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [15:0] gthr = 16'h0, cthr = 16'h0, h2 = 16'h0;
  logic [2:0][15:0] lvl = '0;
  logic [2:0] mode;
  ocpb_side_s s1, s2;
  ocpb_out_s st;
  ocpb_cond_e cond;
  int num_errors = 0, n_compared = 0, cyc = 0;
  always #2 clk = ~clk;
  // short tick keeps every timed count inside a few hundred cycles
  ocpb_stage #(.TICK_CYC(TK)) u_dut (.clk_sys_in(clk), .srst_in(srst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .side1_in(s1), .side2_in(s2), .ext_block_in(blk), .force_enable_in(fen),
    .group_thr_in(gthr), .group_thr_load_in(gld), .comm_thr_in(cthr), .comm_thr_load_in(cld),
    .status_out(st), .cond_out(cond), .mode_out(mode));
  ocpb_meas_model #(.TK(TK)) u_meas (.clk_in(clk), .lvl_in(lvl), .h2_in(h2), .s1_out(s1), .s2_out(s2));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd
  task automatic ticks(input int n);
    repeat (n * TK) @(posedge clk);
  endtask : ticks
  task automatic final_report();
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      final_report();
    end
  end
  // ---
  // tests
  // ---
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(OCPB_GEN_OFS, 32'h200);
    rd(OCPB_THR_OFS, 32'h78);
    rd(OCPB_HARM_OFS, 32'h1);
    apb(1'b0, 12'h020, 32'h0);
    chk(rerr, 1'b1);
    apb(1'b1, OCPB_DLY_OFS, 32'ha0002);
    lvl[1] <= 16'h79;
    ticks(3);
    chk({cond, st}, {OCPB_COND_START, 9'h110});
    apb(1'b0, OCPB_TIME_OFS, 32'h0);
    chk(rdat[31:16], 16'ha);
    chk(rdat[15:0] <= 16'ha && rdat[15:0] != 16'h0, 1'b1);
    lvl[1] <= 16'h75;
    ticks(2);
    chk(st.start, 1'b1);
    lvl[1] <= 16'h74;
    ticks(2);
    chk(st.start, 1'b1);
    ticks(3);
    chk({cond, st}, 11'h0);
    lvl[1] <= 16'h79;
    ticks(13);
    chk({cond, st.trip}, {OCPB_COND_TRIP, 1'b1});
    lvl[1] <= 16'h0;
    ticks(6);
    lvl[0] <= 16'h82;
    ticks(3);
    blk <= 1'b1;
    ticks(6);
    chk(st.start, 1'b0);
    lvl[0] <= 16'h0;
    ticks(6);
    lvl[2] <= 16'h82;
    ticks(3);
    chk({st.start, st.trip, st.blocked}, 3'h1);
    lvl[2] <= 16'h0;
    blk <= 1'b0;
    ticks(6);
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, OCPB_GEN_OFS, 32'h200 | (m << 5));
      ticks(1);
      chk(mode, (m > 4) ? 3'h4 : m[2:0]);
    end
    fen <= 1'b1;
    for (int i = 1; i < 16; i++) begin
      apb(1'b1, OCPB_GEN_OFS, 32'h200 | (i << 10));
      ticks(2);
      if (i < 4) chk(st[9 - i], 1'b1);
      else chk((i > 9) ? st.ph_trip : st.ph_start, (i > 9) ? i - 9 : i - 3);
    end
    apb(1'b1, OCPB_GEN_OFS, 32'h200);
    ticks(2);
    fen <= 1'b0;
    cthr <= 16'hc8;
    cld <= 1'b1;
    @(posedge clk);
    cld <= 1'b0;
    apb(1'b1, OCPB_THR_BUS_OFS, 32'hc8);
    rd(OCPB_THR_OFS, 32'h78);
    apb(1'b1, OCPB_GEN_OFS, 32'h210);
    cld <= 1'b1;
    @(posedge clk);
    cld <= 1'b0;
    rd(OCPB_THR_OFS, 32'hc8);
    apb(1'b1, OCPB_THR_BUS_OFS, 32'hb4);
    rd(OCPB_THR_OFS, 32'hb4);
    gthr <= 16'h64;
    gld <= 1'b1;
    @(posedge clk);
    gld <= 1'b0;
    rd(OCPB_THR_OFS, 32'h64);
    rd(OCPB_GEN_OFS, 32'h210);
    lvl <= {3{16'h96}};
    ticks(3);
    chk(st.ph_start, 3'h7);
    rd(OCPB_RATIO_OFS, 32'h960096);
    lvl <= {32'h0, 16'h46};
    ticks(6);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, OCPB_GEN_OFS, 32'h210);
      ticks(6);
      chk(st.start, 1'b0);
      apb(1'b1, OCPB_GEN_OFS, 32'h210 | (32'h2 << k));
      ticks(6);
      chk(st.start, 1'b1);
    end
    h2 <= 16'h5;
    apb(1'b1, OCPB_GEN_OFS, 32'h310);
    ticks(6);
    lvl[0] <= 16'h82;
    ticks(3);
    chk({st.start, st.blocked}, 2'h1);
    lvl[0] <= 16'h0;
    apb(1'b1, OCPB_HARM_OFS, 32'h1388);
    ticks(6);
    lvl[0] <= 16'h82;
    ticks(3);
    chk({st.start, st.blocked}, 2'h2);
    rd(OCPB_STAT_OFS, 32'h308);
    apb(1'b1, OCPB_GEN_OFS, 32'h10);
    lvl[0] <= 16'h0;
    ticks(2);
    chk(st.start, 1'b0);
    final_report();
  end
endmodule : ocpb_stage_tb
